// file: hw/amp_pkg.sv
package amp_pkg;
  // ****************************************
  // bus geometry
  // ****************************************
  localparam int AMP_DATA_W = 32;          // dword data path
  localparam int AMP_LANES = 4;            // byte lanes per dword
  localparam int AMP_ADDR_W = 5;           // dword address, byte bits [1:0] dropped
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [6:0] AMP_OFF_INBOX = 7'h0C;   // incoming mailbox
  localparam logic [6:0] AMP_OFF_OUTBOX = 7'h1C;  // outgoing mailbox
  localparam logic [6:0] AMP_OFF_PTADDR = 7'h28;  // pass-thru cycle address
  localparam logic [6:0] AMP_OFF_PTDATA = 7'h2C;  // pass-thru cycle data
  // ****************************************
  // field layout and steps
  // ****************************************
  localparam int AMP_IN_FLAG_LSB = 12;     // incoming full flags 15:12
  localparam int AMP_OUT_FLAG_LSB = 28;    // outgoing full flags 31:28
  localparam int AMP_EXT_BYTE = 3;         // byte reachable from external port
  localparam logic [31:0] AMP_ADDR_STEP = 32'h0000_0004; // one dword beat
  localparam logic [31:0] AMP_ZERO = 32'h0000_0000;      // unmapped reads
endpackage : amp_pkg

// file: hw/amp_port.sv
// add-on register port: mailboxes and pass-thru registers
module amp_port
  import amp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // add-on strobed register port
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] local_byte_lanes_n,
  input wire logic [AMP_ADDR_W-1:0] addr,
  input wire logic [31:0] dq_i,
  output logic [31:0] dq_o,
  output logic dq_oe_n,
  // pci side mailbox traffic
  input wire logic pci_in_wr,
  input wire logic [3:0] pci_in_lanes,
  input wire logic [31:0] pci_in_data,
  input wire logic pci_out_rd,
  input wire logic [3:0] pci_out_lanes,
  output logic [31:0] pci_out_data,
  input wire logic pci_irq_rd_en,
  input wire logic pci_irq_wr_en,
  output logic pci_irq_rd,
  output logic pci_irq_wr,
  output logic [31:0] mailbox_fill_status,
  // external mailbox port
  input wire logic ext_mbox_load,
  input wire logic [7:0] ext_mbox_byte,
  // pass-thru cycle side
  input wire logic passive_mode,
  input wire logic pt_claim,
  input wire logic [31:0] pt_addr,
  input wire logic pt_wr_valid,
  input wire logic [31:0] pt_wr_data,
  output logic pt_wr_ready,
  output logic pt_rd_valid,
  output logic [31:0] pt_rd_data,
  input wire logic pt_rd_ready
);
  // ****************************************
  // access decode
  // ****************************************
  wire [6:0] byte_addr = {addr, 2'b00};          // dword address as byte offset
  wire [3:0] lanes = ~local_byte_lanes_n;        // active-high lanes
  wire rd_act = ~sel_n & ~rd_n;                  // read strobe held
  wire wr_act = ~sel_n & ~wr_n;                  // write strobe held
  logic rd_q;                                    // read seen last cycle
  logic wr_q;                                    // write seen last cycle
  wire rd_start = rd_act & ~rd_q;                // side effects once per access
  wire wr_start = wr_act & ~wr_q;
  wire hit_in = (byte_addr == AMP_OFF_INBOX);
  wire hit_out = (byte_addr == AMP_OFF_OUTBOX);
  wire hit_pa = (byte_addr == AMP_OFF_PTADDR);
  wire hit_pd = (byte_addr == AMP_OFF_PTDATA);
  wire in_rd = rd_start & hit_in;
  wire out_wr = wr_start & hit_out;
  wire out_rd = rd_start & hit_out;
  wire pd_rd = rd_start & hit_pd;
  wire pd_wr = wr_start & hit_pd;

  // ****************************************
  // storage
  // ****************************************
  logic [31:0] inbox_q;    // pci to add-on words
  logic [31:0] outbox_q;   // add-on to pci words
  logic [3:0] in_full_q;   // inbox byte full flags
  logic [3:0] out_full_q;  // outbox byte full flags
  logic [31:0] ptaddr_q;   // current pass-thru beat address
  logic [31:0] ptrd_q;     // data written for a pci read
  logic ptrd_v_q;          // that data not yet taken
  logic [31:0] rdata_q;    // read data held on the pins
  logic irq_rd_q;          // inbox read interrupt pulse
  logic irq_wr_q;          // outbox write interrupt pulse
  logic buf_valid;         // pci write word waiting
  logic buf_ready;         // buffer has room
  logic [31:0] buf_data;   // head pci write word

  // strobe history for once-per-access effects
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= rd_act;
      wr_q <= wr_act;
    end
  end

  // ****************************************
  // mailboxes
  // ****************************************
  // no reset on contents: they are undefined until written
  // add-on writes to the inbox are dropped, it is read only here
  always_ff @(posedge mclk) begin
    for (int i = 0; i < AMP_LANES; i++) begin
      if (pci_in_wr & pci_in_lanes[i]) begin
        inbox_q[i*8 +: 8] <= pci_in_data[i*8 +: 8];
      end
      if (out_wr & lanes[i]) begin
        outbox_q[i*8 +: 8] <= dq_i[i*8 +: 8]; // any width write
      end
    end
    // external port overrides a same-cycle add-on write to the top byte
    if (ext_mbox_load) begin
      outbox_q[AMP_EXT_BYTE*8 +: 8] <= ext_mbox_byte;
    end
  end

  // full flags: set wins over a same-cycle clear
  wire [3:0] in_set = pci_in_wr ? pci_in_lanes : 4'h0;
  wire [3:0] in_clr = in_rd ? lanes : 4'h0;
  // the external port only ever reaches the top byte, so only its flag can set here
  wire [3:0] ext_set = ext_mbox_load ? 4'(1 << AMP_EXT_BYTE) : 4'h0;
  wire [3:0] out_set = (out_wr ? lanes : 4'h0) | ext_set;
  wire [3:0] out_clr = pci_out_rd ? pci_out_lanes : 4'h0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_full_q <= 4'h0;
      out_full_q <= 4'h0;
    end else begin
      in_full_q <= (in_full_q & ~in_clr) | in_set;
      out_full_q <= (out_full_q & ~out_clr) | out_set; // add-on outbox reads never clear
    end
  end

  // pci interrupt pulses, only on enabled events
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_rd_q <= 1'b0;
      irq_wr_q <= 1'b0;
    end else begin
      irq_rd_q <= in_rd & pci_irq_rd_en;
      irq_wr_q <= out_wr & pci_irq_wr_en;
    end
  end

  assign pci_irq_rd = irq_rd_q;
  assign pci_irq_wr = irq_wr_q;
  assign pci_out_data = outbox_q;
  always_comb begin
    mailbox_fill_status = AMP_ZERO;
    mailbox_fill_status[AMP_IN_FLAG_LSB +: 4] = in_full_q;
    mailbox_fill_status[AMP_OUT_FLAG_LSB +: 4] = out_full_q;
  end

  // ****************************************
  // pass-thru
  // ****************************************
  // pci write words wait here; an add-on read of the data register pops
  amp_skid2 #(.W(AMP_DATA_W)) u_wbuf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(pt_wr_valid),
    .in_data(pt_wr_data),
    .in_ready(buf_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(pd_rd)
  );

  // passive mode keeps one word outstanding so pci sees waits
  assign pt_wr_ready = buf_ready & ~(passive_mode & buf_valid);

  wire beat_wr = pd_rd & buf_valid;  // pci write beat handed over
  wire beat_rd = pt_rd_valid & pt_rd_ready; // pci read beat taken

  // address: captured on claim, then one dword per beat
  always_ff @(posedge mclk) begin
    if (pt_claim) begin
      ptaddr_q <= pt_addr;
    end else if (beat_wr | beat_rd) begin
      ptaddr_q <= ptaddr_q + AMP_ADDR_STEP;
    end
  end

  // read-direction data written by the add-on
  always_ff @(posedge mclk) begin
    if (pd_wr) begin
      ptrd_q <= dq_i;
    end
  end

  // pci read held in wait until the add-on supplies the word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptrd_v_q <= 1'b0;
    end else if (pd_wr) begin
      ptrd_v_q <= 1'b1;
    end else if (pt_rd_ready) begin
      ptrd_v_q <= 1'b0;
    end
  end

  assign pt_rd_valid = ptrd_v_q;
  assign pt_rd_data = ptrd_q;

  // ****************************************
  // read path
  // ****************************************
  // data register shows pending pci write data, else the add-on's last word
  wire [31:0] pd_view = buf_valid ? buf_data : ptrd_q;
  wire [31:0] rd_mux = hit_in ? inbox_q :
                       hit_out ? outbox_q :
                       hit_pa ? ptaddr_q :
                       hit_pd ? pd_view : AMP_ZERO; // unmapped reads zero

  // whole dword captured, the add-on picks its lanes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= AMP_ZERO;
    end else if (rd_start) begin
      rdata_q <= rd_mux;
    end
  end

  assign dq_o = rdata_q;
  assign dq_oe_n = ~(rd_act & rd_q); // drive from second read cycle on

  // ****************************************
  // checks
  // ****************************************
  // an enabled inbox read must reach the host as one pulse
  in_rd_irq_a: assert property (@(posedge mclk) disable iff (rst)
    in_rd & pci_irq_rd_en |=> pci_irq_rd) else $error("inbox read irq missing");
  // no pulse without an enabled inbox read
  no_rd_irq_a: assert property (@(posedge mclk) disable iff (rst)
    !(in_rd & pci_irq_rd_en) |=> !pci_irq_rd) else $error("spurious inbox irq");
  // outbox write pulses exactly when the host enabled it
  out_wr_irq_a: assert property (@(posedge mclk) disable iff (rst)
    out_wr |=> pci_irq_wr == $past(pci_irq_wr_en)) else $error("outbox write irq wrong");
  // external load lands in the top byte and marks it full
  ext_load_a: assert property (@(posedge mclk) disable iff (rst)
    ext_mbox_load |=> pci_out_data[AMP_EXT_BYTE*8 +: 8] == $past(ext_mbox_byte)
    && mailbox_fill_status[AMP_OUT_FLAG_LSB + AMP_EXT_BYTE])
    else $error("external byte not loaded");
  // a plain outbox read leaves flags and interrupts alone
  out_rd_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    out_rd & !pci_in_wr & !pci_out_rd & !ext_mbox_load |=> $stable(mailbox_fill_status) && !pci_irq_wr
    && !pci_irq_rd) else $error("outbox read had side effect");
  // add-on writes never reach the inbox
  inbox_ro_a: assert property (@(posedge mclk) disable iff (rst)
    wr_start & hit_in & !pci_in_wr |=> $stable(inbox_q)) else $error("inbox written by add-on");
  // a claim loads the cycle address
  claim_cap_a: assert property (@(posedge mclk) disable iff (rst)
    pt_claim |=> ptaddr_q == $past(pt_addr)) else $error("claim address not captured");
  // each completed beat moves on by one dword
  addr_step_a: assert property (@(posedge mclk) disable iff (rst)
    (beat_wr | beat_rd) & !pt_claim |=> ptaddr_q == $past(ptaddr_q) + AMP_ADDR_STEP)
    else $error("address step wrong");
  // a waiting word in passive mode holds the host off
  passive_wait_a: assert property (@(posedge mclk) disable iff (rst)
    passive_mode & buf_valid |-> !pt_wr_ready) else $error("passive write not stalled");
  // in passive mode an accepted word blocks the next one
  passive_hold_a: assert property (@(posedge mclk) disable iff (rst)
    passive_mode & pt_wr_valid & pt_wr_ready |=> !(passive_mode & pt_wr_ready))
    else $error("passive word not held");
  // add-on data for a host read is offered on the next edge
  pd_write_a: assert property (@(posedge mclk) disable iff (rst)
    pd_wr |=> pt_rd_valid && pt_rd_data == $past(dq_i)) else $error("read data not offered");
  // a taken read beat withdraws its offer unless new data arrived
  rd_taken_a: assert property (@(posedge mclk) disable iff (rst)
    pt_rd_valid & pt_rd_ready & !pd_wr |=> !pt_rd_valid) else $error("read beat not withdrawn");
  // a host write sets the flags of its lanes
  in_flag_a: assert property (@(posedge mclk) disable iff (rst)
    pci_in_wr |=> (mailbox_fill_status[AMP_IN_FLAG_LSB +: 4] & $past(pci_in_lanes)) == $past(pci_in_lanes))
    else $error("inbox flag not set");
  // an add-on write sets the outbox flags of its lanes
  out_flag_a: assert property (@(posedge mclk) disable iff (rst)
    out_wr |=> (mailbox_fill_status[AMP_OUT_FLAG_LSB +: 4] & $past(lanes)) == $past(lanes))
    else $error("outbox flag not set");
  // an inbox read empties its lanes when the host is not refilling them
  in_clear_a: assert property (@(posedge mclk) disable iff (rst)
    in_rd & !pci_in_wr |=> (mailbox_fill_status[AMP_IN_FLAG_LSB +: 4] & $past(lanes)) == 4'h0)
    else $error("inbox flag not cleared");
  // inbox read hands back the whole dword one edge later
  in_rd_data_a: assert property (@(posedge mclk) disable iff (rst)
    in_rd |=> dq_o == $past(inbox_q)) else $error("inbox read data wrong");
  // outbox readback shows what the host side sees
  out_rd_data_a: assert property (@(posedge mclk) disable iff (rst)
    out_rd |=> dq_o == $past(pci_out_data)) else $error("outbox read data wrong");
  // address register reads back the current beat address
  pa_rd_data_a: assert property (@(posedge mclk) disable iff (rst)
    rd_start & hit_pa |=> dq_o == $past(ptaddr_q)) else $error("address read wrong");
  // a write beat handed over is the buffered head word
  pd_rd_data_a: assert property (@(posedge mclk) disable iff (rst)
    beat_wr |=> dq_o == $past(buf_data)) else $error("write beat data wrong");
  // read data stands on the pins until the next read starts
  rdata_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !rd_start |=> $stable(dq_o)) else $error("read data moved");
endmodule : amp_port

// file: hw/amp_skid2.sv
// two-entry buffer, valid/ready on both sides
module amp_skid2 #(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  // ****************************************
  // storage
  // ****************************************
  logic [W-1:0] slot0_q; // head entry
  logic [W-1:0] slot1_q; // second entry
  logic [1:0] cnt_q;     // occupancy 0..2
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = slot0_q;

  // occupancy; honest full so the source really stalls
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
    end else if (push & ~pop) begin
      cnt_q <= cnt_q + 2'h1;
    end else if (pop & ~push) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  // data slots carry no reset, contents are don't-care until pushed
  always_ff @(posedge mclk) begin
    if (pop) begin
      slot0_q <= (cnt_q == 2'h2) ? slot1_q : in_data;
    end else if (push & (cnt_q == 2'h0)) begin
      slot0_q <= in_data;
    end
    if (push & (cnt_q == 2'h2 || (cnt_q == 2'h1 & ~pop))) begin
      slot1_q <= in_data;
    end
  end
endmodule : amp_skid2

// file: tb/addon_mailbox_passthru_regs_test.sv
// self-checking bench for the add-on mailbox and pass-thru port
module addon_mailbox_passthru_regs_test
  import amp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic mclk = 1'b0, rst = 1'b1;
  logic sel_n, rd_n, wr_n, dq_oe_n;
  logic [3:0] local_byte_lanes_n;
  logic [AMP_ADDR_W-1:0] addr;
  logic [31:0] dq_i, dq_o, pci_out_data, mailbox_fill_status, pt_rd_data, rdat;
  logic pci_in_wr = 0, pci_out_rd = 0, pci_irq_rd_en = 0, pci_irq_wr_en = 0, pci_irq_rd, pci_irq_wr;
  logic [3:0] pci_in_lanes = 4'hF, pci_out_lanes = 4'hF;
  logic [31:0] pci_in_data = 32'h0, pt_addr = 32'h0, pt_wr_data = 32'h0;
  logic ext_mbox_load = 0, passive_mode = 0, pt_claim = 0, pt_wr_valid = 0, pt_rd_ready = 0;
  logic [7:0] ext_mbox_byte = 8'h00;
  logic pt_wr_ready, pt_rd_valid;
  logic oe_seen; // port's output enable as seen during an access
  int error_cnt = 0, checked = 0, irq_rd_seen = 0, irq_wr_seen = 0;
  always #10 mclk = ~mclk; // 50 MHz
  // interrupt pulses are single cycles, so count them at every rising edge
  always @(posedge mclk) begin
    if (pci_irq_rd === 1'b1) irq_rd_seen++;
    if (pci_irq_wr === 1'b1) irq_wr_seen++;
  end
  amp_port amp_port_inst (.mclk(mclk), .rst(rst), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .local_byte_lanes_n(local_byte_lanes_n), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .pci_in_wr(pci_in_wr), .pci_in_lanes(pci_in_lanes), .pci_in_data(pci_in_data), .pci_out_rd(pci_out_rd),
    .pci_out_lanes(pci_out_lanes), .pci_out_data(pci_out_data), .pci_irq_rd_en(pci_irq_rd_en),
    .pci_irq_wr_en(pci_irq_wr_en), .pci_irq_rd(pci_irq_rd), .pci_irq_wr(pci_irq_wr),
    .mailbox_fill_status(mailbox_fill_status), .ext_mbox_load(ext_mbox_load), .ext_mbox_byte(ext_mbox_byte),
    .passive_mode(passive_mode), .pt_claim(pt_claim), .pt_addr(pt_addr), .pt_wr_valid(pt_wr_valid),
    .pt_wr_data(pt_wr_data), .pt_wr_ready(pt_wr_ready), .pt_rd_valid(pt_rd_valid), .pt_rd_data(pt_rd_data),
    .pt_rd_ready(pt_rd_ready));
  amp_addon_model amp_addon_model_inst (.mclk(mclk), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .local_byte_lanes_n(local_byte_lanes_n), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // each access ends one falling edge later so one-cycle pulses have been counted
  task automatic wr(input logic [6:0] off, input logic [3:0] ln, input logic [31:0] d);
    amp_addon_model_inst.acc(1'b1, off[6:2], ln, d, rdat, oe_seen);
    @(negedge mclk);
    chk(oe_seen, 1);
  endtask : wr
  task automatic rd(input logic [6:0] off, input logic [3:0] ln, input logic [31:0] exp);
    amp_addon_model_inst.acc(1'b0, off[6:2], ln, 32'h0, rdat, oe_seen);
    chk(rdat, exp);
    chk(oe_seen, 0);
    @(negedge mclk);
    chk(dq_oe_n, 1);
  endtask : rd
  // a host-side pulse lasting one cycle, launched off the falling edge
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  task automatic push(input logic [31:0] d);
    @(negedge mclk);
    pt_wr_data = d;
    pt_wr_valid = 1'b1;
    @(negedge mclk);
    pt_wr_valid = 1'b0;
    pt_wr_data = ~d;
  endtask : push
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_inbox();
    pci_irq_rd_en = 1'b1;
    pci_in_data = 32'hA1B2_C3D4;
    pulse(pci_in_wr);
    chk(mailbox_fill_status, 32'h0000_F000);
    rd(AMP_OFF_INBOX, 4'hE, 32'hA1B2_C3D4);
    chk(irq_rd_seen, 1);
    chk(mailbox_fill_status, 32'h0000_E000);
    pci_irq_rd_en = 1'b0;
    wr(AMP_OFF_INBOX, 4'h0, 32'h0000_0000);
    rd(AMP_OFF_INBOX, 4'h0, 32'hA1B2_C3D4);
    chk(irq_rd_seen, 1);
    chk(mailbox_fill_status, 32'h0);
    pci_in_lanes = 4'h3;
    pci_in_data = 32'h0000_5566;
    pulse(pci_in_wr);
    chk(mailbox_fill_status, 32'h0000_3000);
    rd(AMP_OFF_INBOX, 4'h0, 32'hA1B2_5566);
    chk(mailbox_fill_status, 32'h0);
    pci_in_lanes = 4'hF;
  endtask : t_inbox
  task automatic t_outbox();
    wr(AMP_OFF_OUTBOX, 4'h0, 32'h1122_3344);
    chk(irq_wr_seen, 0);
    pci_irq_wr_en = 1'b1;
    wr(AMP_OFF_OUTBOX, 4'hD, 32'hAAAA_AAAA);
    chk(irq_wr_seen, 1);
    chk(pci_out_data, 32'h1122_AA44);
    chk(mailbox_fill_status, 32'hF000_0000);
    rd(AMP_OFF_OUTBOX, 4'h0, 32'h1122_AA44);
    chk(mailbox_fill_status, 32'hF000_0000);
    chk(irq_wr_seen + irq_rd_seen, 2);
    pulse(pci_out_rd);
    chk(mailbox_fill_status, 32'h0);
    ext_mbox_byte = 8'h5A;
    pulse(ext_mbox_load);
    chk(mailbox_fill_status, 32'h8000_0000);
    chk(pci_out_data, 32'h5A22_AA44);
    pci_out_lanes = 4'h7;
    pulse(pci_out_rd);
    chk(mailbox_fill_status, 32'h8000_0000);
    pci_out_lanes = 4'h8;
    pulse(pci_out_rd);
    chk(mailbox_fill_status, 32'h0);
    pci_out_lanes = 4'hF;
    rd(7'h7C, 4'h0, AMP_ZERO);
  endtask : t_outbox
  task automatic t_passthru();
    pt_addr = 32'h0000_1000;
    pulse(pt_claim);
    push(32'hD00D_0001);
    push(32'hD00D_0002);
    chk(pt_wr_ready, 0); // both buffer entries held
    rd(AMP_OFF_PTADDR, 4'h0, 32'h0000_1000);
    rd(AMP_OFF_PTDATA, 4'h0, 32'hD00D_0001);
    rd(AMP_OFF_PTADDR, 4'h0, 32'h0000_1004);
    rd(AMP_OFF_PTDATA, 4'h0, 32'hD00D_0002);
    wr(AMP_OFF_PTDATA, 4'h0, 32'hCAFE_0001);
    repeat (3) @(negedge mclk);
    chk(pt_rd_valid, 1); // stalled receiver keeps the offer
    chk(pt_rd_data, 32'hCAFE_0001);
    pulse(pt_rd_ready);
    chk(pt_rd_valid, 0);
    rd(AMP_OFF_PTADDR, 4'h0, 32'h0000_100C);
    passive_mode = 1'b1;
    push(32'hD00D_0003);
    chk(pt_wr_ready, 0);
    rd(AMP_OFF_PTDATA, 4'h0, 32'hD00D_0003);
    chk(pt_wr_ready, 1);
  endtask : t_passthru
  // ****************************************
  // verdict and main sequence
  // ****************************************
  task automatic results();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    #200us;
    error_cnt++;
    results();
  end
  initial begin
    repeat (12) @(negedge mclk);
    chk(mailbox_fill_status, 32'h0);
    chk(dq_oe_n, 1);
    rst = 1'b0;
    t_inbox();
    t_outbox();
    t_passthru();
    results();
  end
endmodule : addon_mailbox_passthru_regs_test

// file: tb/amp_addon_model.sv
// add-on side logic model: strobed register accesses on the local port
module amp_addon_model
  import amp_pkg::*;
(
  input wire logic mclk,
  output logic sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] local_byte_lanes_n,
  output logic [AMP_ADDR_W-1:0] addr,
  output logic [31:0] dq_i,
  input wire logic [31:0] dq_o,
  input wire logic dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // idle bus
  // ****************************************
  initial begin
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    local_byte_lanes_n = 4'hF;
    addr = '0;
    dq_i = 32'h5A5A_5A5A;
  end
  // ****************************************
  // one access: strobes held over one rising edge, answer taken on the next falling edge
  // ****************************************
  task automatic acc(input logic wr, input logic [AMP_ADDR_W-1:0] a, input logic [3:0] ln,
                     input logic [31:0] wd, output logic [31:0] rdat, output logic oe_n);
    @(negedge mclk);
    sel_n = 1'b0; // select, lanes and strobe all change off the sampling edge
    addr = a;
    local_byte_lanes_n = ln; // any width: byte, word or dword lanes
    if (wr) begin
      wr_n = 1'b0;
      dq_i = wd; // returned data for a host read goes in by a write
    end else begin
      rd_n = 1'b0;
    end
    @(posedge mclk);
    @(negedge mclk);
    rdat = dq_o;
    oe_n = dq_oe_n; // enable sampled while the strobe still stands
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    // released data and address lines never keep the last value, so a stale sample cannot pass
    dq_i = ~dq_i;
    addr = ~addr;
  endtask : acc
endmodule : amp_addon_model
